/* pkg/output_mux_consts.vh */
`ifndef OUTPUT_MUX_CONSTS_VH
`define OUTPUT_MUX_CONSTS_VH

// Position word
`define POS_WIDTH          8
`define POS_RESET          8'h00

// Shared data line positions
`define LINE_SERIAL        7
`define LINE_COSINE        5
`define LINE_SINE          4
`define LINE_QUAD_FIRST    3
`define LINE_REF_MARK      2
`define LINE_QUAD_SECOND   1
`define LINE_UNUSED        0

// Incremental resolutions, pulses per revolution
`define PPR_HIGH           64
`define PPR_LOW            32
`define PPR_FACTORY        16

// Angle bits below the quadrature phase, per resolution
`define SHIFT_64PPR        0
`define SHIFT_32PPR        1
`define SHIFT_16PPR        2

// Serial link
`define SERIAL_BITS        8
`define MONO_TIME_US       20
`define CLK_MHZ            50
`define MONO_CYCLES        (`MONO_TIME_US * `CLK_MHZ)

`endif

/* design/encoder_output_mode_mux.v */
// Behaviour
// - Mode select low gives parallel output, high gives serial plus incremental, with pins reassigned.
// - Mode, latch/resolution and disable inputs read low when unconnected, thanks to pull-downs.
// - In parallel mode a high latch input freezes all eight position bits.
// - In parallel mode a low latch input lets the word refresh with every new angle.
// - In serial mode the incremental output gives 64 ppr with resolution low and 32 ppr with it high.
// - 16 ppr is only a factory setting, never chosen by the resolution input.
// - A high disable input floats all eight lines in parallel mode, and every line but sine and cosine in serial mode.
// - The disable input leaves the buffered sine and cosine outputs driven.
// - In parallel mode the least significant bit sits on line 0.
// - In serial mode line 2 carries the reference mark, line 1 quadrature B, line 0 is unused.
// - In serial mode the serial clock input is the interrogation clock, driven by the host.
// - Line 7 carries the position MSB in parallel mode and serial data in serial mode.
// - In serial mode line 3 carries quadrature A.
// - The reference mark pulses once a revolution for a quarter of a quadrature period.
`timescale 1ns/1ns
`include "output_mux_consts.vh"

module encoder_output_mode_mux #(
    parameter                    POS_W       = `POS_WIDTH,
    parameter                    MONO_CYC    = `MONO_CYCLES,
    parameter                    FACTORY_16  = 0
) (
    input  wire                  sys_clk,
    input  wire                  arst_n,
    input  wire [POS_W-1:0]      angle,
    input  wire                  angle_valid,
    input  wire                  output_mode_select,
    input  wire                  latch_or_resolution_input,
    input  wire                  output_disable,
    input  wire                  serial_clock_in,
    input  wire                  sine_buffered,
    input  wire                  cosine_buffered,
    output reg  [7:0]            data_out,
    output reg  [7:0]            data_oe,
    output reg                   mode_serial
);

    // Pin synchronisers: two flops before any logic reads a pin
    // Index 0 mode, 1 latch/resolution, 2 disable, 3 serial clock
    localparam       N_SYNC     = 4;
    // Pull-downs make floating pins read low; the serial clock idles high
    localparam [3:0] SYNC_RESET = 4'h8;

    wire [N_SYNC-1:0] pin_raw = {serial_clock_in, output_disable,
                                 latch_or_resolution_input, output_mode_select};
    wire [N_SYNC-1:0] sync_bus;
    reg               sclk_prev_q;

    genvar g;
    generate
        for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
            reg meta_q;
            reg sync_q;

            always @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q <= SYNC_RESET[g];
                    sync_q <= SYNC_RESET[g];
                end else begin
                    meta_q <= pin_raw[g];
                    sync_q <= meta_q;
                end
            end

            assign sync_bus[g] = sync_q;
        end
    endgenerate

    // Previous serial clock level, for edge detection
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sync_bus[3];
        end
    end

    wire serial_mode                   = sync_bus[0];
    wire parallel_freeze               = sync_bus[1] & ~serial_mode;
    wire incremental_resolution_select = sync_bus[1];
    wire outputs_off                   = sync_bus[2];
    wire sclk_fall                     = sclk_prev_q & ~sync_bus[3];
    wire sclk_rise                     = ~sclk_prev_q & sync_bus[3];
    wire sclk_edge                     = sclk_fall | sclk_rise;

    // Parallel word capture
    reg [POS_W-1:0] par_word_q;
    reg [POS_W-1:0] par_word_d;
    reg             freeze_prev_q;

    always @* begin
        par_word_d = par_word_q;
        if (!parallel_freeze && freeze_prev_q) begin
            // On release the angle loads at once, without waiting for angle_valid
            par_word_d = angle;
        end else if (!parallel_freeze && angle_valid) begin
            par_word_d = angle;
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            par_word_q    <= `POS_RESET;
            freeze_prev_q <= 1'b0;
        end else begin
            freeze_prev_q <= parallel_freeze;
            par_word_q    <= par_word_d;
        end
    end

    // Incremental outputs from the angle: quadrature phase is two angle bits
    function [1:0] quad_phase;
        input [POS_W-1:0] a;
        input [1:0]       shift;
        reg   [POS_W-1:0] s;
        begin
            s = a >> shift;
            quad_phase = s[1:0];
        end
    endfunction

    reg [1:0] res_shift;
    always @* begin
        if (FACTORY_16 != 0)
            res_shift = 2'd`SHIFT_16PPR;
        else if (incremental_resolution_select)
            res_shift = 2'd`SHIFT_32PPR;
        else
            res_shift = 2'd`SHIFT_64PPR;
    end

    wire [1:0] phase = quad_phase(angle, res_shift);
    // Gray sequence per phase: B leads A
    wire quad_b = phase[1] ^ phase[0];
    wire quad_a = phase[1];

    // Reference mark: one phase slot at angle zero = quarter period
    // Three-bit sum: the 16 ppr shift plus two must not wrap to zero
    reg [POS_W-1:0] ref_mask;
    always @* begin
        ref_mask = {POS_W{1'b1}} << ({1'b0, res_shift} + 3'h2);
    end
    wire ref_hit = ((angle & ref_mask) == {POS_W{1'b0}}) && (phase == 2'b00);

    // Synchronous serial transmitter, one-hot states
    localparam [2:0]  ST_IDLE   = 3'b001;
    localparam [2:0]  ST_SHIFT  = 3'b010;
    localparam [2:0]  ST_GAP    = 3'b100;
    localparam [15:0] MONO_LOAD = MONO_CYC;
    localparam [3:0]  LAST_BIT  = `SERIAL_BITS;

    reg [2:0]       ser_state_q;
    reg [POS_W-1:0] shift_q;
    reg [3:0]       bit_cnt_q;
    reg             sdata_q;
    reg [15:0]      mono_q;
    wire            mono_expired = (mono_q == 16'h0001) && !sclk_edge;

    // Monoflop, retriggered by every serial clock edge
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mono_q <= 16'h0000;
        end else if (!serial_mode) begin
            mono_q <= 16'h0000;
        end else if (sclk_edge) begin
            mono_q <= MONO_LOAD;
        end else if (mono_q != 16'h0000) begin
            mono_q <= mono_q - 16'h0001;
        end
    end

    // Clock edges arrive three cycles late; the host must keep half periods longer
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ser_state_q <= ST_IDLE;
            shift_q     <= `POS_RESET;
            bit_cnt_q   <= 4'h0;
            sdata_q     <= 1'b1;
        end else if (!serial_mode) begin
            ser_state_q <= ST_IDLE;
            sdata_q     <= 1'b1;
        end else begin
            case (ser_state_q)
                ST_IDLE: begin
                    sdata_q <= 1'b1;
                    if (sclk_fall) begin
                        shift_q     <= angle;
                        bit_cnt_q   <= 4'h0;
                        ser_state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (mono_expired) begin
                        sdata_q     <= 1'b1;
                        ser_state_q <= ST_IDLE;
                    end else if (sclk_rise && bit_cnt_q != LAST_BIT) begin
                        sdata_q   <= shift_q[POS_W-1];
                        shift_q   <= {shift_q[POS_W-2:0], shift_q[POS_W-1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (sclk_fall && bit_cnt_q == LAST_BIT) begin
                        // Least significant bit done: line drops low
                        sdata_q     <= 1'b0;
                        bit_cnt_q   <= 4'h0;
                        ser_state_q <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (mono_expired) begin
                        sdata_q     <= 1'b1;
                        ser_state_q <= ST_IDLE;
                    end else if (sclk_rise) begin
                        // Repeat read: one zero, then the same word again
                        sdata_q     <= 1'b0;
                        ser_state_q <= ST_SHIFT;
                    end
                end
                default: begin
                    sdata_q     <= 1'b1;
                    ser_state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Next line values and enables, per mode
    reg [7:0] data_d;
    reg [7:0] oe_d;

    always @* begin
        data_d = 8'h00;
        oe_d   = 8'h00;
        if (!serial_mode) begin
            data_d = par_word_q;
            oe_d   = outputs_off ? 8'h00 : 8'hFF;
        end else begin
            data_d[`LINE_SERIAL]      = sdata_q;
            data_d[`LINE_COSINE]      = cosine_buffered;
            data_d[`LINE_SINE]        = sine_buffered;
            data_d[`LINE_QUAD_FIRST]  = quad_a;
            data_d[`LINE_REF_MARK]    = ref_hit;
            data_d[`LINE_QUAD_SECOND] = quad_b;
            // Line 6 and line 0 float in this mode
            oe_d[`LINE_COSINE] = 1'b1;
            oe_d[`LINE_SINE]   = 1'b1;
            if (!outputs_off) begin
                oe_d[`LINE_SERIAL]      = 1'b1;
                oe_d[`LINE_QUAD_FIRST]  = 1'b1;
                oe_d[`LINE_REF_MARK]    = 1'b1;
                oe_d[`LINE_QUAD_SECOND] = 1'b1;
            end
        end
    end

    // Pin register: every line leaves straight from a flop
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out    <= 8'h00;
            data_oe     <= 8'h00;
            mode_serial <= 1'b0;
        end else begin
            mode_serial <= serial_mode;
            data_out    <= data_d;
            data_oe     <= oe_d;
        end
    end

endmodule // encoder_output_mode_mux

/* tb/encoder_output_mode_mux_assertions.sv */
`timescale 1ns/1ns
module mux_checker (
    input wire       sys_clk,
    input wire       arst_n,
    input wire [7:0] angle,
    input wire       angle_valid,
    input wire       output_mode_select,
    input wire       latch_or_resolution_input,
    input wire       output_disable,
    input wire [7:0] data_out,
    input wire [7:0] data_oe,
    input wire       mode_serial
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire ser = output_mode_select;
    wire par = !output_mode_select;
    wire frz = par && latch_or_resolution_input;
    property p_mode; !ser[*3] ##1 ser |-> !mode_serial[*3] ##1 mode_serial; endproperty
    a_mode: assert property (p_mode) else $error("mode lag wrong");
    property p_float; output_disable[*4] |-> (data_oe & 8'hCF) == 8'h00; endproperty
    a_float: assert property (p_float) else $error("lines driven while off");
    property p_analog; ser[*4] |-> data_oe[5:4] == 2'b11; endproperty
    a_analog: assert property (p_analog) else $error("analog line floated");
    property p_unused; ser[*4] |-> data_oe[0] == 1'b0 && data_oe[6] == 1'b0; endproperty
    a_unused: assert property (p_unused) else $error("unused line driven");
    property p_serdrv; (ser && !output_disable)[*4] |-> (data_oe & 8'h8E) == 8'h8E; endproperty
    a_serdrv: assert property (p_serdrv) else $error("serial lines idle");
    property p_pardrv; (par && !output_disable)[*4] |-> data_oe == 8'hFF; endproperty
    a_pardrv: assert property (p_pardrv) else $error("parallel lines idle");
    property p_freeze; frz[*6] |-> $stable(data_out); endproperty
    a_freeze: assert property (p_freeze) else $error("frozen word moved");
    property p_refresh;
        (par && !latch_or_resolution_input)[*4] ##0 angle_valid |-> ##2 data_out == $past(angle, 2);
    endproperty
    a_refresh: assert property (p_refresh) else $error("word not refreshed");
endmodule // mux_checker
bind encoder_output_mode_mux mux_checker i_mux_checker (.sys_clk(sys_clk), .arst_n(arst_n),
    .angle(angle), .angle_valid(angle_valid), .output_mode_select(output_mode_select),
    .latch_or_resolution_input(latch_or_resolution_input), .output_disable(output_disable),
    .data_out(data_out), .data_oe(data_oe), .mode_serial(mode_serial));

/* tb/host_reader.sv */
`timescale 1ns/1ns
module host_reader (
    input  wire sys_clk,
    input  wire serial_data,
    output reg  serial_clock
);
    initial serial_clock = 1'b1;
    // Half periods well above sync lag, below the monoflop time
    task read_word(output [7:0] w);
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                @(negedge sys_clk) serial_clock = 1'b0;
                repeat (8) @(negedge sys_clk);
                serial_clock = 1'b1;
                repeat (8) @(negedge sys_clk);
                w = {w[6:0], serial_data};
            end
            repeat (60) @(negedge sys_clk);
        end
    endtask
endmodule // host_reader

/* tb/encoder_output_mode_mux_bench.sv */
`timescale 1ns/1ns
module encoder_output_mode_mux_bench;
    reg        sys_clk = 1'b0;
    reg        arst_n = 1'b0;
    reg  [7:0] angle = 8'h00;
    reg        latch = 1'b0;
    reg        mode = 1'b0;
    reg        off = 1'b0;
    wire       sclk;
    wire [7:0] data_out;
    wire [7:0] data_oe;
    wire       mode_ser;
    integer    fail_count = 0;
    integer    num_checks = 0;
    integer    res, k, qa, rm;
    reg  [7:0] w;
    reg        pa;
    always #10 sys_clk = ~sys_clk;
    encoder_output_mode_mux #(.MONO_CYC(20)) i_encoder_output_mode_mux (.sys_clk(sys_clk),
        .arst_n(arst_n), .angle(angle), .angle_valid(1'b1), .output_mode_select(mode),
        .latch_or_resolution_input(latch), .output_disable(off), .serial_clock_in(sclk),
        .sine_buffered(1'b0), .cosine_buffered(1'b1), .data_out(data_out),
        .data_oe(data_oe), .mode_serial(mode_ser));
    host_reader i_host_reader (.sys_clk(sys_clk), .serial_data(data_out[7]), .serial_clock(sclk));
    task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task settle;
        repeat (6) @(negedge sys_clk);
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        arst_n = 1'b1;
        angle = 8'hA5;
        settle;
        chk("par", 8'hA5, data_out);
        chk("par_oe", 8'hFF, data_oe);
        chk("mode_par", 8'h00, {7'h00, mode_ser});
        latch = 1'b1;
        settle;
        angle = 8'h3C;
        settle;
        chk("frozen", 8'hA5, data_out);
        latch = 1'b0;
        settle;
        chk("release", 8'h3C, data_out);
        $display("parallel done");
        off = 1'b1;
        settle;
        chk("off_oe", 8'h00, data_oe);
        mode = 1'b1;
        settle;
        chk("ser_off", 8'h30, data_oe);
        chk("mode_ser", 8'h01, {7'h00, mode_ser});
        off = 1'b0;
        settle;
        chk("ser_oe", 8'hBE, data_oe);
        chk("analog", 8'h02, {6'h00, data_out[5:4]});
        angle = 8'h96;
        i_host_reader.read_word(w);
        chk("ssi", 8'h96, w);
        $display("serial done");
        for (res = 0; res < 2; res = res + 1) begin
            latch = res[0];
            angle = 8'h00;
            qa = 0;
            rm = 0;
            settle;
            pa = data_out[3];
            for (k = 1; k <= 256; k = k + 1) begin
                angle = k[7:0];
                settle;
                if (data_out[3] === 1'b1 && pa === 1'b0)
                    qa = qa + 1;
                if (data_out[2] === 1'b1)
                    rm = rm + 1;
                pa = data_out[3];
            end
            chk("quad", 8'h40 >> res, qa[7:0]);
            chk("refmark", 8'h01 << res, rm[7:0]);
        end
        $display("incremental done");
        results;
    end
endmodule // encoder_output_mode_mux_bench
